// *** design/multifunction_pin_config.sv ***
// multifunction pin configuration registers, input filters and pin function muxing
//
// Function
// - pin 1 codes: general, driver enable, processor reset, power good outputs
// - pin 2 codes: general, second bus clock, spi chip select, watchdog trigger
// - pin 3 codes: general, second bus data, codes 2 and 3 spi data out
// - pin 4 codes: general, enable input, watchdog trigger, converter 1 monitor
// - codes 4 to 7 on any pin: sleep 1, sleep 2, wake 1, wake 2
// - filter bit 0 only synchronises; 1 needs 8 us stable input
// - bit 3 enables the pin pull resistor
// - bit 2 picks pull-down or pull-up, only while pull enabled
// - bit 1 picks push-pull or open-drain for outputs
// - bit 0 sets direction: 0 input, 1 output
// - pin 1 register resets to 0x2A
// - pin 2, 3, 4 registers reset to 0x0A
`timescale 1ns/1ns
module multifunction_pin_config #(
    parameter int DEGLITCH_CYCLES = pin_mux_pkg::DEGLITCH_CYCLES
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // register access port
    input wire pin_mux_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    // pins
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out_q,
    output logic [3:0] pin_oe_q,
    output logic [3:0] pull_up_en_q,
    output logic [3:0] pull_down_en_q,
    // device signals driven onto pins
    input wire logic [3:0] gpio_out_val,
    input wire logic driver_enable_out,
    input wire logic processor_reset_out,
    input wire logic power_good_out,
    input wire logic second_bus_clock_out,
    input wire logic second_bus_data_out,
    input wire logic serial_data_out,
    // device signals taken from pins
    output logic [3:0] gpio_in_q,
    output logic second_bus_clock_in_q,
    output logic second_bus_data_in_q,
    output logic spi_cs_in_q,
    output logic watchdog_trigger_in_q,
    output logic enable_in_q,
    output logic converter1_monitor_sel_q,
    output logic sleep_request_1_q,
    output logic sleep_request_2_q,
    output logic wake_request_1_q,
    output logic wake_request_2_q
);
    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    pin_mux_pkg::pin_cfg_t cfg_q [4];
    logic [3:0] filt_q;
    logic [1:0] reg_idx;
    logic reg_hit;

    // 0x31..0x34 map to index 0..3 by subtracting one from the low bits
    assign reg_hit = (reg_req.addr >= pin_mux_pkg::PIN1_CONFIG_OFFSET)
                  && (reg_req.addr <= pin_mux_pkg::PIN4_CONFIG_OFFSET);
    assign reg_idx = reg_req.addr[1:0] - 2'h1;

    // read port answers one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata_q <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end
        else if (clk_en)
        begin
            reg_rvalid_q <= reg_req.rd;
            if (reg_req.rd)
                reg_rdata_q <= reg_hit ? cfg_q[reg_idx] : pin_mux_pkg::UNMAPPED_READ;
        end
    end

    // ----------------------------------------------------------------
    // per-pin registers, synchronisers, filters and drivers
    // ----------------------------------------------------------------
    logic [3:0] drive_val;

    genvar gi;
    generate
        for (gi = 0; gi < pin_mux_pkg::NUM_PINS; gi++)
        begin : g_pin
            localparam logic [7:0] RST_VAL = (gi == 0) ? pin_mux_pkg::PIN1_CONFIG_RESET
                                                       : pin_mux_pkg::PINX_CONFIG_RESET;
            logic sync1_q;
            logic sync2_q;
            logic [pin_mux_pkg::DEGLITCH_CNT_W-1:0] cnt_q;
            logic differs;
            logic cnt_done;

            // reset value stands in for the non-volatile default load
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                    cfg_q[gi] <= pin_mux_pkg::pin_cfg_t'(RST_VAL);
                else if (clk_en && reg_req.wr && reg_hit && reg_idx == 2'(gi))
                    cfg_q[gi] <= pin_mux_pkg::pin_cfg_t'(reg_req.wdata);
            end

            // two-flop synchroniser; only sync2_q is looked at
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    sync1_q <= 1'b0;
                    sync2_q <= 1'b0;
                end
                else if (clk_en)
                begin
                    sync1_q <= pin_in[gi];
                    sync2_q <= sync1_q;
                end
            end

            assign differs = sync2_q != filt_q[gi];
            assign cnt_done = cnt_q == pin_mux_pkg::DEGLITCH_CNT_W'(DEGLITCH_CYCLES - 1);

            // any bounce back to the old level restarts the stability count
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    cnt_q <= '0;
                    filt_q[gi] <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (!cfg_q[gi].pin_filter_enable || !differs)
                    begin
                        cnt_q <= '0;
                        filt_q[gi] <= sync2_q;
                    end
                    else if (cnt_done)
                    begin
                        cnt_q <= '0;
                        filt_q[gi] <= sync2_q;
                    end
                    else
                        cnt_q <= cnt_q + 1'b1;
                end
            end

            // open-drain only ever pulls low, so its data line stays zero
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    pin_out_q[gi] <= 1'b0;
                    pin_oe_q[gi] <= 1'b0;
                    pull_up_en_q[gi] <= 1'b0;
                    pull_down_en_q[gi] <= 1'b0;
                end
                else if (clk_en)
                begin
                    pin_out_q[gi] <= !cfg_q[gi].pin_driver_type && drive_val[gi];
                    pin_oe_q[gi] <= cfg_q[gi].pin_direction
                                 && (!cfg_q[gi].pin_driver_type || !drive_val[gi]);
                    pull_up_en_q[gi] <= cfg_q[gi].pin_pull_enable
                                     && cfg_q[gi].pin_pull_direction;
                    pull_down_en_q[gi] <= cfg_q[gi].pin_pull_enable
                                       && !cfg_q[gi].pin_pull_direction;
                end
            end

            a_filter_wait: assert property (@(posedge ref_clk) disable iff (!arst_n)
                (clk_en && cfg_q[gi].pin_filter_enable && differs) |=>
                    (filt_q[gi] == $past(filt_q[gi])) || $past(cnt_done))
                else $error("filtered input changed before the stable time");
            a_pull_gating: assert property (@(posedge ref_clk) disable iff (!arst_n)
                (clk_en && !cfg_q[gi].pin_pull_enable) |=>
                    !pull_up_en_q[gi] && !pull_down_en_q[gi])
                else $error("pull resistor on while disabled");
            a_pull_side: assert property (@(posedge ref_clk) disable iff (!arst_n)
                (clk_en && cfg_q[gi].pin_pull_enable) |=>
                    pull_up_en_q[gi] == $past(cfg_q[gi].pin_pull_direction))
                else $error("pull direction wrong");
            a_od_low_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
                (clk_en && cfg_q[gi].pin_driver_type) |=> !pin_out_q[gi])
                else $error("open-drain pin drives high");
            a_input_float: assert property (@(posedge ref_clk) disable iff (!arst_n)
                (clk_en && !cfg_q[gi].pin_direction) |=> !pin_oe_q[gi])
                else $error("input pin is driven");
        end
    endgenerate

    // ----------------------------------------------------------------
    // function muxing
    // ----------------------------------------------------------------
    logic [2:0] sel1;
    logic [2:0] sel2;
    logic [2:0] sel3;
    logic [2:0] sel4;
    assign sel1 = cfg_q[0].pin_function_select;
    assign sel2 = cfg_q[1].pin_function_select;
    assign sel3 = cfg_q[2].pin_function_select;
    assign sel4 = cfg_q[3].pin_function_select;

    // value each pin would drive; input-only functions fall back to zero
    assign drive_val[0] = (sel1 == pin_mux_pkg::FN_GENERAL) ? gpio_out_val[0]
                        : (sel1 == pin_mux_pkg::FN_ALT1) ? driver_enable_out
                        : (sel1 == pin_mux_pkg::FN_ALT2) ? processor_reset_out
                        : (sel1 == pin_mux_pkg::FN_ALT3) ? power_good_out : 1'b0;
    assign drive_val[1] = (sel2 == pin_mux_pkg::FN_GENERAL) ? gpio_out_val[1]
                        : (sel2 == pin_mux_pkg::FN_ALT1) ? second_bus_clock_out : 1'b0;
    assign drive_val[2] = (sel3 == pin_mux_pkg::FN_GENERAL) ? gpio_out_val[2]
                        : (sel3 == pin_mux_pkg::FN_ALT1) ? second_bus_data_out
                        : (sel3 == pin_mux_pkg::FN_ALT2 || sel3 == pin_mux_pkg::FN_ALT3)
                          ? serial_data_out : 1'b0;
    assign drive_val[3] = (sel4 == pin_mux_pkg::FN_GENERAL) ? gpio_out_val[3] : 1'b0;

    // lowest-numbered pin carrying the code wins; none selected reads zero
    function automatic logic pick_input(input logic [2:0] code,
                                        input logic [2:0] s0, input logic [2:0] s1,
                                        input logic [2:0] s2, input logic [2:0] s3,
                                        input logic [3:0] lvl);
        logic r;
        r = 1'b0;
        if (s0 == code) r = lvl[0];
        else if (s1 == code) r = lvl[1];
        else if (s2 == code) r = lvl[2];
        else if (s3 == code) r = lvl[3];
        return r;
    endfunction : pick_input

    logic wdog_d;
    assign wdog_d = ((sel2 == pin_mux_pkg::FN_ALT3) && filt_q[1])
                 || ((sel4 == pin_mux_pkg::FN_ALT2) && filt_q[3]);

    // core-facing inputs are registered so every output leaves a flop
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gpio_in_q <= 4'h0;
            second_bus_clock_in_q <= 1'b0;
            second_bus_data_in_q <= 1'b0;
            spi_cs_in_q <= 1'b0;
            watchdog_trigger_in_q <= 1'b0;
            enable_in_q <= 1'b0;
            converter1_monitor_sel_q <= 1'b0;
            sleep_request_1_q <= 1'b0;
            sleep_request_2_q <= 1'b0;
            wake_request_1_q <= 1'b0;
            wake_request_2_q <= 1'b0;
        end
        else if (clk_en)
        begin
            gpio_in_q <= filt_q;
            second_bus_clock_in_q <= (sel2 == pin_mux_pkg::FN_ALT1) && filt_q[1];
            spi_cs_in_q <= (sel2 == pin_mux_pkg::FN_ALT2) && filt_q[1];
            second_bus_data_in_q <= (sel3 == pin_mux_pkg::FN_ALT1) && filt_q[2];
            enable_in_q <= (sel4 == pin_mux_pkg::FN_ALT1) && filt_q[3];
            watchdog_trigger_in_q <= wdog_d;
            converter1_monitor_sel_q <= sel4 == pin_mux_pkg::FN_ALT3;
            sleep_request_1_q <= pick_input(pin_mux_pkg::FN_SLEEP1, sel1, sel2, sel3, sel4,
                                            filt_q);
            sleep_request_2_q <= pick_input(pin_mux_pkg::FN_SLEEP2, sel1, sel2, sel3, sel4,
                                            filt_q);
            wake_request_1_q <= pick_input(pin_mux_pkg::FN_WAKE1, sel1, sel2, sel3, sel4,
                                           filt_q);
            wake_request_2_q <= pick_input(pin_mux_pkg::FN_WAKE2, sel1, sel2, sel3, sel4,
                                           filt_q);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_pin1_reset_out: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (clk_en && sel1 == pin_mux_pkg::FN_ALT2 && !cfg_q[0].pin_driver_type
         && cfg_q[0].pin_direction) |=>
            pin_oe_q[0] && pin_out_q[0] == $past(processor_reset_out))
        else $error("pin 1 does not carry processor reset");
    a_pin2_chip_sel: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (clk_en && sel2 == pin_mux_pkg::FN_ALT2) |=> spi_cs_in_q == $past(filt_q[1]))
        else $error("pin 2 chip select not passed");
    a_pin3_data_out: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (clk_en && sel3 == pin_mux_pkg::FN_ALT3 && !cfg_q[2].pin_driver_type) |=>
            pin_out_q[2] == $past(serial_data_out))
        else $error("pin 3 code 3 is not spi data out");
    a_pin4_monitor: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_en |=> converter1_monitor_sel_q == ($past(sel4) == pin_mux_pkg::FN_ALT3))
        else $error("monitor select does not follow pin 4 code");
    a_sleep_pick: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (clk_en && sel1 == pin_mux_pkg::FN_SLEEP1) |=>
            sleep_request_1_q == $past(filt_q[0]))
        else $error("sleep request 1 not taken from pin 1");
    a_sync_depth: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (clk_en && !cfg_q[0].pin_filter_enable)[*4] |-> filt_q[0] == $past(pin_in[0], 3))
        else $error("unfiltered input path is not three flops deep");
endmodule : multifunction_pin_config

// *** design/pin_mux_pkg.sv ***
// shared constants and types of the multifunction pin configuration block
package pin_mux_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] PIN1_CONFIG_OFFSET = 8'h31;
    localparam logic [7:0] PIN2_CONFIG_OFFSET = 8'h32;
    localparam logic [7:0] PIN3_CONFIG_OFFSET = 8'h33;
    localparam logic [7:0] PIN4_CONFIG_OFFSET = 8'h34;
    localparam logic [7:0] PIN1_CONFIG_RESET = 8'h2A;
    localparam logic [7:0] PINX_CONFIG_RESET = 8'h0A;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int NUM_PINS = 4;

    // ----------------------------------------------------------------
    // function select codes
    // ----------------------------------------------------------------
    localparam logic [2:0] FN_GENERAL = 3'h0;
    localparam logic [2:0] FN_ALT1 = 3'h1;
    localparam logic [2:0] FN_ALT2 = 3'h2;
    localparam logic [2:0] FN_ALT3 = 3'h3;
    localparam logic [2:0] FN_SLEEP1 = 3'h4;
    localparam logic [2:0] FN_SLEEP2 = 3'h5;
    localparam logic [2:0] FN_WAKE1 = 3'h6;
    localparam logic [2:0] FN_WAKE2 = 3'h7;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEGLITCH_TIME_NS = 8000;
    localparam int DEGLITCH_CYCLES = (DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEGLITCH_CNT_W = 10;

    // one pin register, msb first: select 7:5, filter 4, pull 3, up 2, od 1, dir 0
    typedef struct packed {
        logic [2:0] pin_function_select;
        logic pin_filter_enable;
        logic pin_pull_enable;
        logic pin_pull_direction;
        logic pin_driver_type;
        logic pin_direction;
    } pin_cfg_t;

    // register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : pin_mux_pkg

// *** verif/multifunction_pin_config_tb_top.sv ***
// self-checking bench of the multifunction pin configuration block
`timescale 1ns/1ns
module multifunction_pin_config_tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    pin_mux_pkg::reg_req_t reg_req = '0;
    logic [7:0] reg_rdata_q;
    logic reg_rvalid_q;
    logic [3:0] pin_in, pin_out_q, pin_oe_q, pull_up_en_q, pull_down_en_q, gpio_in_q;
    logic [3:0] gpio_out_val = '0;
    logic [5:0] src = '0; // drv en, proc reset, power good, bus clock, bus data, spi out
    logic [3:0] ext_en = 4'hF;
    logic [3:0] ext_lvl = '0;
    logic [9:0] fn_q;
    logic [7:0] cfg [4];
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 53154;
    int cycles = 0;

    multifunction_pin_config #(.DEGLITCH_CYCLES(8)) uut (.ref_clk(ref_clk), .arst_n(arst_n),
        .clk_en(clk_en), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q), .pin_in(pin_in), .pin_out_q(pin_out_q),
        .pin_oe_q(pin_oe_q), .pull_up_en_q(pull_up_en_q), .pull_down_en_q(pull_down_en_q),
        .gpio_out_val(gpio_out_val), .driver_enable_out(src[0]),
        .processor_reset_out(src[1]), .power_good_out(src[2]),
        .second_bus_clock_out(src[3]), .second_bus_data_out(src[4]),
        .serial_data_out(src[5]), .gpio_in_q(gpio_in_q),
        .second_bus_clock_in_q(fn_q[0]), .second_bus_data_in_q(fn_q[1]),
        .spi_cs_in_q(fn_q[2]), .watchdog_trigger_in_q(fn_q[3]), .enable_in_q(fn_q[4]),
        .converter1_monitor_sel_q(fn_q[5]), .sleep_request_1_q(fn_q[6]),
        .sleep_request_2_q(fn_q[7]), .wake_request_1_q(fn_q[8]),
        .wake_request_2_q(fn_q[9]));

    pin_partner far_side (.ref_clk(ref_clk), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q),
        .pull_up_en_q(pull_up_en_q), .pull_down_en_q(pull_down_en_q), .ext_en(ext_en),
        .ext_lvl(ext_lvl), .pin_in(pin_in));

    // ------------------------------------------------------------
    // clock, hang guard and shared tasks
    // ------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;

    // the whole run needs well under 5000 cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        tick(1);
        reg_req.wr = 1'b0;
        tick(1);
    endtask : reg_write

    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        tick(1);
        check({1'b0, reg_rvalid_q, reg_rdata_q}, {2'b01, exp}, "read");
        reg_req.rd = 1'b0;
        tick(1);
    endtask : reg_read

    // value a pin would carry out for its selected code
    function automatic logic drive_value(input int i, input int code);
        logic [3:0] v [4];
        v[0] = {src[2], src[1], src[0], gpio_out_val[0]};
        v[1] = {1'b0, 1'b0, src[3], gpio_out_val[1]};
        v[2] = {src[5], src[5], src[4], gpio_out_val[2]};
        v[3] = {3'h0, gpio_out_val[3]};
        // sleep and wake codes are inputs only and drive nothing
        return (code < 4) ? v[i][code] : 1'b0;
    endfunction : drive_value

    // reference model: pin drive, pulls and every function input
    task automatic check_pins();
        logic [3:0] oe, out, up, dn, w;
        logic [9:0] fn;
        int code [4];
        fn = '0;
        for (int i = 0; i < 4; i++)
        begin
            code[i] = cfg[i][7:5];
            up[i] = cfg[i][3] & cfg[i][2];
            dn[i] = cfg[i][3] & ~cfg[i][2];
            out[i] = cfg[i][1] ? 1'b0 : drive_value(i, code[i]);
            oe[i] = cfg[i][0] & (cfg[i][1] ? ~drive_value(i, code[i]) : 1'b1);
            w[i] = oe[i] ? out[i] : ext_en[i] ? ext_lvl[i] : up[i];
        end
        for (int i = 3; i >= 0; i--)
            if (code[i] >= 4)
                fn[code[i] + 2] = w[i];
        fn[0] = (code[1] == 1) & w[1];
        fn[1] = (code[2] == 1) & w[2];
        fn[2] = (code[1] == 2) & w[1];
        fn[3] = ((code[1] == 3) & w[1]) | ((code[3] == 2) & w[3]);
        fn[4] = (code[3] == 1) & w[3];
        fn[5] = (code[3] == 3);
        check({2'b00, pin_oe_q, pin_out_q}, {2'b00, oe, out}, "drive");
        check({2'b00, pull_up_en_q, pull_down_en_q}, {2'b00, up, dn}, "pulls");
        check({6'h00, gpio_in_q}, {6'h00, w}, "pin level");
        check(fn_q, fn, "functions");
    endtask : check_pins

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] r;
        tick(20);
        arst_n = 1'b1;
        tick(2);
        check({2'b00, pull_up_en_q, pull_down_en_q}, 10'h00F, "reset pulls");
        foreach (cfg[i])
            reg_read(pin_mux_pkg::PIN1_CONFIG_OFFSET + 8'(i), i == 0 ? 8'h2A : 8'h0A);
        reg_read(8'h35, pin_mux_pkg::UNMAPPED_READ);
        clk_en = 1'b0;
        reg_write(pin_mux_pkg::PIN1_CONFIG_OFFSET, 8'hFF);
        clk_en = 1'b1;
        reg_read(pin_mux_pkg::PIN1_CONFIG_OFFSET, 8'h2A);
        // every code on every pin, with random fields, levels and sources
        for (int it = 0; it < 24; it++)
        begin
            r = $random(seed);
            {src, gpio_out_val} = r[9:0];
            for (int i = 0; i < 4; i++)
            begin
                r = $random(seed);
                cfg[i] = {3'((it + i * 3) % 8), 1'b0, r[3:0]};
                if (it < 8)
                    cfg[i][1:0] = 2'b01; // first pass: push-pull output for every code that drives the pin; input-only codes become inputs
                if (cfg[i][7:5] > (i == 1 ? 1 : i == 3 ? 0 : 3))
                    cfg[i][0] = 1'b0;
                ext_lvl[i] = r[4];
                ext_en[i] = ~cfg[i][0] | (cfg[i][1] & drive_value(i, cfg[i][7:5]));
            end
            for (int i = 0; i < 4; i++)
                reg_write(pin_mux_pkg::PIN1_CONFIG_OFFSET + 8'(i), cfg[i]);
            tick(10);
            check_pins();
            foreach (cfg[i])
                reg_read(pin_mux_pkg::PIN1_CONFIG_OFFSET + 8'(i), cfg[i]);
        end
        // deglitch: a short pulse is dropped, a long level passes
        cfg[0] = 8'h10;
        ext_en = 4'hF;
        ext_lvl = 4'h0;
        reg_write(pin_mux_pkg::PIN1_CONFIG_OFFSET, cfg[0]);
        tick(12);
        ext_lvl[0] = 1'b1;
        tick(5);
        ext_lvl[0] = 1'b0;
        repeat (14)
        begin
            tick(1);
            check({9'h000, gpio_in_q[0]}, 10'h000, "short pulse");
        end
        ext_lvl[0] = 1'b1;
        tick(10);
        check({9'h000, gpio_in_q[0]}, 10'h000, "filter wait");
        tick(1);
        check({9'h000, gpio_in_q[0]}, 10'h001, "filter pass");
        // filter off: synchroniser delay only
        reg_write(pin_mux_pkg::PIN1_CONFIG_OFFSET, 8'h00);
        tick(4);
        ext_lvl[0] = 1'b0;
        tick(3);
        check({9'h000, gpio_in_q[0]}, 10'h001, "sync hold");
        tick(1);
        check({9'h000, gpio_in_q[0]}, 10'h000, "sync pass");
        report_and_stop();
    end
endmodule : multifunction_pin_config_tb_top

// *** verif/pin_partner.sv ***
// system logic on the four pins: external drivers, pull resistors and floating lines
`timescale 1ns/1ns
module pin_partner (
    // clock
    input wire logic ref_clk,
    // pin controls from the device
    input wire logic [3:0] pin_out_q,
    input wire logic [3:0] pin_oe_q,
    input wire logic [3:0] pull_up_en_q,
    input wire logic [3:0] pull_down_en_q,
    // external drivers
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_lvl,
    // resolved pin levels
    output logic [3:0] pin_in
);
    // a released line with no pull wanders, so never let it look stable
    logic [3:0] float_q = 4'h5;

    always @(posedge ref_clk)
        float_q <= ~float_q;

    // device driver first, then external driver, then pull resistor
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pin_in[i] = pin_oe_q[i] ? pin_out_q[i] : ext_en[i] ? ext_lvl[i] :
                        pull_up_en_q[i] ? 1'b1 : pull_down_en_q[i] ? 1'b0 : float_q[i];
    end
endmodule : pin_partner
